/* File: rtl/pmt_pkg.sv */
// constants, register map and carrier types of the period match timer
// assumes one 100 MHz system clock and a synchronous active-high reset
package pmt_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int INST_DIV = 4;
    localparam int INST_PHASE_W = 2;
    localparam logic [INST_PHASE_W-1:0] INST_LAST =
        INST_PHASE_W'(INST_DIV - 1);

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int PRESC_W = 4;

    localparam logic [ADDR_W-1:0] ADDR_COUNT = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_PRIO = 3'h5;

    localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LIMIT_RESET = 8'hFF;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h7F;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;

    localparam int MATCH_BIT = 0;

    localparam logic [1:0] PSEL_DIV1 = 2'h0;
    localparam logic [1:0] PSEL_DIV4 = 2'h1;
    localparam int PSEL_HI = 1;
    localparam logic [PRESC_W-1:0] PRESC_LAST_1 = 4'h0;
    localparam logic [PRESC_W-1:0] PRESC_LAST_4 = 4'h3;
    localparam logic [PRESC_W-1:0] PRESC_LAST_16 = 4'hF;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 4'h0;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 4'h1;

    typedef struct packed {
        logic unused;
        logic [3:0] match_divider_select;
        logic counter_on;
        logic [1:0] input_divider_select;
    } pmt_ctrl_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pmt_bus_req_type;

endpackage

/* File: rtl/pmt_divider.sv */
// modulo tick divider used as prescaler and as postscaler
// assumes tick and clear come from logic on clk_sys
`timescale 1ns/10ps
module pmt_divider (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [pmt_pkg::PRESC_W-1:0] last,
    output logic pulse_q
);
    import pmt_pkg::*;

    logic [PRESC_W-1:0] count_q;

    // >= so that lowering the ratio mid-count cannot overshoot
    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            count_q <= PRESC_ZERO;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            if (tick) begin
                if (count_q >= last) begin
                    count_q <= PRESC_ZERO;
                    pulse_q <= 1'b1;
                end else begin
                    count_q <= count_q + PRESC_ONE;
                end
            end
        end
    end

endmodule

/* File: rtl/pmt_timer.sv */
// 8-bit period match timer with prescaler, postscaler and interrupt
// assumes a register master on clk_sys that never overlaps strobes
`timescale 1ns/10ps

// Overview of operation
// - count clock is system clock divided by four
// - counter steps by one on each prescaled edge
// - prescaler offers divide by one, four, sixteen
// - compare counter with limit every cycle
// - on match clear counter, pulse the postscaler
// - counter and limit are 8-bit, read/write
// - reset clears counter, sets limit to ones
// - count or control write clears both dividers
// - control write leaves the counter untouched
// - postscaler ratio reached sets sticky match flag
// - sixteen postscale ratios, one to sixteen
// - enable gates interrupt, priority bit applied
// - unscaled match pulse offered to other blocks
// - postscale ratio equals select value plus one
// - divider codes 00 one, 01 four, 1x sixteen
// - counter runs only while on bit set
// - sleep freezes counter and limit contents
module pmt_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sleep,
    input wire pmt_pkg::pmt_bus_req_type bus_req,
    output logic [pmt_pkg::DATA_W-1:0] rdata_q,
    output logic irq_q,
    output logic irq_high_priority_q,
    output logic match_out_q,
    output logic match_equal_q
);
    import pmt_pkg::*;

    logic [INST_PHASE_W-1:0] phase_q;
    logic [DATA_W-1:0] period_count_q;
    logic [DATA_W-1:0] period_limit_q;
    pmt_ctrl_type counter_control_q;
    logic match_irq_flag_q;
    logic match_irq_enable_q;
    logic match_irq_priority_q;

    logic inst_tick;
    logic wr_count;
    logic wr_limit;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_prio;
    logic div_clear;
    logic presc_pulse_q;
    logic post_pulse_q;
    logic [PRESC_W-1:0] presc_last;
    logic [PRESC_W-1:0] presc_gap_q;
    logic counts_equal;
    logic advance;
    logic match_evt;

    assign wr_count = bus_req.wr && (bus_req.addr == ADDR_COUNT);
    assign wr_limit = bus_req.wr && (bus_req.addr == ADDR_LIMIT);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
    assign wr_status = bus_req.wr && (bus_req.addr == ADDR_STATUS);
    assign wr_mask = bus_req.wr && (bus_req.addr == ADDR_MASK);
    assign wr_prio = bus_req.wr && (bus_req.addr == ADDR_PRIO);

    // instruction clock phase, frozen in sleep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_q <= '0;
        end else if (!sleep) begin
            phase_q <= phase_q + INST_PHASE_W'(1);
        end
    end

    assign inst_tick = (phase_q == INST_LAST) && !sleep;

    // divider codes
    always_comb begin
        presc_last = PRESC_LAST_16;
        if (counter_control_q.input_divider_select[PSEL_HI]) begin
            presc_last = PRESC_LAST_16;
        end else if (counter_control_q.input_divider_select == PSEL_DIV4) begin
            presc_last = PRESC_LAST_4;
        end else if (counter_control_q.input_divider_select == PSEL_DIV1) begin
            presc_last = PRESC_LAST_1;
        end
    end

    assign div_clear = wr_count || wr_ctrl;

    pmt_divider u_prescaler (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(div_clear),
        .tick(inst_tick && counter_control_q.counter_on),
        .last(presc_last),
        .pulse_q(presc_pulse_q)
    );

    // cycles since the last prescaler pulse or clear, saturating
    always_ff @(posedge clk_sys) begin
        if (rst || div_clear || presc_pulse_q) begin
            presc_gap_q <= PRESC_ZERO;
        end else if (presc_gap_q != PRESC_LAST_16) begin
            presc_gap_q <= presc_gap_q + PRESC_ONE;
        end
    end

    assign counts_equal = (period_count_q == period_limit_q);
    // a software count write wins over the step
    assign advance = presc_pulse_q && counter_control_q.counter_on &&
        !sleep && !wr_count;
    assign match_evt = advance && counts_equal;

    // counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            period_count_q <= COUNT_RESET;
        end else if (wr_count) begin
            period_count_q <= bus_req.wdata;
        end else if (advance) begin
            if (counts_equal) begin
                period_count_q <= COUNT_RESET;
            end else begin
                period_count_q <= period_count_q + COUNT_ONE;
            end
        end
    end

    // period limit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            period_limit_q <= LIMIT_RESET;
        end else if (wr_limit) begin
            period_limit_q <= bus_req.wdata;
        end
    end

    // control register; top bit reads as zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            counter_control_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            counter_control_q <= bus_req.wdata & CTRL_WR_MASK;
        end
    end

    // postscaler: ratio is select plus one
    pmt_divider u_postscaler (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(div_clear),
        .tick(match_evt),
        .last(counter_control_q.match_divider_select),
        .pulse_q(post_pulse_q)
    );

    // sticky flag, write one clears, set wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_irq_flag_q <= 1'b0;
        end else if (post_pulse_q) begin
            match_irq_flag_q <= 1'b1;
        end else if (wr_status && bus_req.wdata[MATCH_BIT]) begin
            match_irq_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_irq_enable_q <= 1'b0;
        end else if (wr_mask) begin
            match_irq_enable_q <= bus_req.wdata[MATCH_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_irq_priority_q <= 1'b0;
        end else if (wr_prio) begin
            match_irq_priority_q <= bus_req.wdata[MATCH_BIT];
        end
    end

    // interrupt outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
            irq_high_priority_q <= 1'b0;
        end else begin
            irq_q <= match_irq_flag_q && match_irq_enable_q;
            irq_high_priority_q <= match_irq_priority_q;
        end
    end

    // match outputs for other blocks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_out_q <= 1'b0;
            match_equal_q <= 1'b0;
        end else begin
            match_out_q <= match_evt;
            match_equal_q <= counts_equal;
        end
    end

    // read port, data in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= READ_ZERO;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_COUNT: begin
                    rdata_q <= period_count_q;
                end
                ADDR_LIMIT: begin
                    rdata_q <= period_limit_q;
                end
                ADDR_CTRL: begin
                    rdata_q <= counter_control_q;
                end
                ADDR_STATUS: begin
                    rdata_q <= DATA_W'(match_irq_flag_q);
                end
                ADDR_MASK: begin
                    rdata_q <= DATA_W'(match_irq_enable_q);
                end
                ADDR_PRIO: begin
                    rdata_q <= DATA_W'(match_irq_priority_q);
                end
                default: begin
                    rdata_q <= READ_ZERO;
                end
            endcase
        end else begin
            rdata_q <= READ_ZERO;
        end
    end

    inst_rate_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        inst_tick |=> !inst_tick [*3])
        else $error("instruction tick faster than one in four");

    count_step_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        advance && !counts_equal |=>
            period_count_q == $past(period_count_q) + COUNT_ONE)
        else $error("counter did not step by one");

    presc_div4_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        presc_pulse_q &&
            counter_control_q.input_divider_select == PSEL_DIV4
            |-> presc_gap_q > PRESC_LAST_4)
        else $error("divide by four prescaler pulsed too soon");

    match_out_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        match_out_q |-> $past(period_count_q) == $past(period_limit_q))
        else $error("match pulse without equal values");

    count_clear_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        advance && counts_equal |=>
            period_count_q == COUNT_RESET && match_out_q)
        else $error("match did not clear counter");

    reset_values_a: assert property (
        @(posedge clk_sys)
        rst |=> period_count_q == COUNT_RESET &&
            period_limit_q == LIMIT_RESET)
        else $error("wrong values after reset");

    div_clear_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        div_clear |=> !presc_pulse_q && !post_pulse_q)
        else $error("dividers not cleared by write");

    ctrl_keep_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_ctrl && !advance |=> $stable(period_count_q))
        else $error("control write changed the counter");

    flag_set_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        post_pulse_q |=> match_irq_flag_q ##1
            irq_q == $past(match_irq_enable_q))
        else $error("postscaler pulse did not set flag");

    irq_gate_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !match_irq_enable_q |=> !irq_q)
        else $error("interrupt raised while disabled");

    off_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !counter_control_q.counter_on && !wr_count |=>
            $stable(period_count_q))
        else $error("counter moved while off");

    sleep_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        sleep && !wr_count && !wr_limit |=>
            $stable(period_count_q) && $stable(period_limit_q))
        else $error("timer moved during sleep");

endmodule

/* File: test/pmt_timer_tb.sv */
// self-checking bench for the period match timer
// drives the register port and sleep itself; design asserts stand inside
`timescale 1ns/10ps
module pmt_timer_tb;
    import pmt_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sleep = 1'b0;
    pmt_bus_req_type bus_req = '0;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q, irq_high_priority_q, match_out_q, match_equal_q;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'h1db5;
    logic [7:0] v, w;
    int n;
    bit seen_equal = 0;

    pmt_timer pmt_timer_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .sleep(sleep),
        .bus_req(bus_req),
        .rdata_q(rdata_q),
        .irq_q(irq_q),
        .irq_high_priority_q(irq_high_priority_q),
        .match_out_q(match_out_q),
        .match_equal_q(match_equal_q)
    );

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (match_equal_q === 1'b1) seen_equal = 1;
        if (cycles == 30000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function automatic logic [7:0] ctrl(input logic [3:0] sel,
                                       input logic on, input logic [1:0] dv);
        pmt_ctrl_type c;
        c = '{1'b0, sel, on, dv};
        return c;
    endfunction

    // cycles between two match pulses for a divider code and limit
    function automatic int exp_period(input logic [1:0] dv,
                                      input logic [7:0] lim);
        int d;
        d = (dv == PSEL_DIV1) ? 1 : (dv == PSEL_DIV4) ? 4 : 16;
        return INST_DIV * d * (int'(lim) + 1);
    endfunction

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
        d = rdata_q;
    endtask

    task automatic match_gap(output int p);
        int k;
        k = 0;
        while (match_out_q !== 1'b1 && k < 2000) begin
            step();
            k++;
        end
        step();
        p = 1;
        while (match_out_q !== 1'b1 && p < 2000) begin
            step();
            p++;
        end
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_COUNT, v); check(v, COUNT_RESET, "count reset");
        rd(ADDR_LIMIT, v); check(v, LIMIT_RESET, "limit reset");
        rd(ADDR_CTRL, v); check(v, CTRL_RESET, "control reset");
        rd(3'h6, v); check(v, READ_ZERO, "unmapped read");
        check({7'h00, irq_high_priority_q}, 8'h00, "priority reset");
        // random register traffic, timer stopped
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            wr(ADDR_LIMIT, rnd[7:0]);
            wr(ADDR_COUNT, rnd[15:8]);
            rd(ADDR_LIMIT, v); check(v, rnd[7:0], "limit rw");
            rd(ADDR_COUNT, v); check(v, rnd[15:8], "count rw");
        end
        // off holds the count
        repeat (40) @(posedge clk_sys);
        rd(ADDR_COUNT, v); check(v, rnd[15:8], "count held off");
        // control write keeps the count
        wr(ADDR_COUNT, 8'h20);
        wr(ADDR_CTRL, ctrl(4'h0, 1'b1, 2'h2));
        rd(ADDR_COUNT, v); check(v, 8'h20, "count kept");
        // counting from zero, div1
        wr(ADDR_LIMIT, 8'hFF);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL, ctrl(4'h0, 1'b1, 2'h0));
        repeat (40) @(posedge clk_sys);
        rd(ADDR_COUNT, v);
        check(8'(v >= 8'd8 && v <= 8'd11), 8'h01, "count rate");
        @(posedge clk_sys);
        sleep <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(ADDR_COUNT, v);
        repeat (40) @(posedge clk_sys);
        rd(ADDR_COUNT, w); check(w, v, "sleep holds count");
        rd(ADDR_LIMIT, w); check(w, 8'hFF, "sleep holds limit");
        @(posedge clk_sys);
        sleep <= 1'b0;
        // match period for every divider code, random small limit
        for (int c = 0; c < 4; c++) begin
            rnd = xs(rnd);
            wr(ADDR_LIMIT, {6'h00, rnd[1:0]} + 8'h01);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CTRL, ctrl(4'h0, 1'b1, 2'(c)));
            match_gap(n);
            check(8'(n == exp_period(2'(c), {6'h00, rnd[1:0]} + 8'h01)),
                  8'h01, "match period");
        end
        check(8'(seen_equal), 8'h01, "equal seen");
        // postscaler ratio for every select value
        wr(ADDR_LIMIT, 8'h01);
        wr(ADDR_MASK, 8'h01);
        for (int s = 0; s < 16; s++) begin
            wr(ADDR_CTRL, ctrl(4'(s), 1'b0, 2'h0));
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_STATUS, 8'h01);
            wr(ADDR_CTRL, ctrl(4'(s), 1'b1, 2'h0));
            repeat (2) step();
            n = 0;
            for (int k = 0; k < 400 && irq_q !== 1'b1; k++) begin
                step();
                if (match_out_q === 1'b1) n++;
            end
            check(8'(n), 8'(s + 1), "postscale ratio");
        end
        // mask gates the line, flag stays until cleared
        wr(ADDR_CTRL, ctrl(4'hF, 1'b0, 2'h0));
        wr(ADDR_MASK, 8'h00);
        repeat (2) step();
        check({7'h00, irq_q}, 8'h00, "masked irq");
        rd(ADDR_STATUS, v); check(v, 8'h01, "flag sticky");
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, v); check(v, 8'h00, "flag cleared");
        wr(ADDR_PRIO, 8'h01);
        repeat (2) step();
        check({7'h00, irq_high_priority_q}, 8'h01, "priority");
        stop_test();
    end
endmodule
